/* File: serial_status_pkg.sv */
// constants, field positions and carrier types of the serial status block
// assumes a byte-addressed register port with 32-bit data, one clock domain
// How it works
// - receive element count in bits 28..24
// - transmit element count in bits 20..16
// - framing error in framed mode sets frame error flag
// - activity flag high while transaction runs
// - empty transmit buffer on demand sets underrun in framed mode
// - underrun clears by re-enable or zero write
// - shift register empty flag mirrors shifter
// - word into full receive buffer discarded, overflow
// - overflow clears only by re-enable, zero write
// - receive empty when read equals write pointer
// - unimplemented status bits read zero
package serial_status_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PTR_W = 5;
    localparam int IDX_W = 4;
    localparam int FLAG_W = 4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h10;
    // status field positions
    localparam int POS_RX_COUNT = 24;
    localparam int POS_TX_COUNT = 16;
    localparam int POS_FRAME_ERR = 12;
    localparam int POS_ACTIVITY = 11;
    localparam int POS_TX_UNDERRUN = 8;
    localparam int POS_SHIFT_EMPTY = 7;
    localparam int POS_RX_OVERFLOW = 6;
    localparam int POS_RX_EMPTY = 5;
    localparam int POS_TX_EMPTY = 3;
    localparam int POS_TX_FULL = 1;
    localparam int POS_RX_FULL = 0;
    // control field positions
    localparam int POS_ON = 0;
    localparam int POS_ENH = 1;
    localparam int POS_FRAMED = 2;
    // interrupt event positions
    localparam int EV_FRAME_ERR = 0;
    localparam int EV_TX_UNDERRUN = 1;
    localparam int EV_RX_OVERFLOW = 2;
    localparam int EV_RX_WORD = 3;
    // buffer depths in each mode
    localparam logic [PTR_W-1:0] DEPTH_ENHANCED = 5'h10;
    localparam logic [PTR_W-1:0] DEPTH_STANDARD = 5'h01;
    // reset values
    localparam logic [FLAG_W-1:0] RST_FLAGS = 4'h0;
    localparam logic RST_SHIFT_EMPTY = 1'b1;
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    typedef struct packed {
        logic framed_mode_enable;
        logic enhanced_buffer_enable;
        logic on;
    } control_t;
    typedef struct packed {
        logic rx_word;
        logic rx_overflow;
        logic tx_underrun;
        logic frame_error;
    } events_t;
    localparam control_t RST_CONTROL = '{default: 1'b0};
endpackage : serial_status_pkg

/* File: sticky_flag.sv */
// one hardware-set, software-cleared flag
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
    import serial_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic set,
    input wire logic clear,
    // state
    output logic flag
);
    logic flag_reg;
    logic flag_next;

    // set wins over a clear in the same cycle
    assign flag_next = set | (flag_reg & ~clear);
    assign flag = flag_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end
endmodule : sticky_flag
`default_nettype wire

/* File: buffer_tracker.sv */
// read and write pointers and occupancy of one buffer
// assumes push is never given while full nor pop while empty
`timescale 1ns/1ps
`default_nettype none
module buffer_tracker
    import serial_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [PTR_W-1:0] depth,
    // state
    output logic [PTR_W-1:0] wr_ptr,
    output logic [PTR_W-1:0] rd_ptr,
    output logic [PTR_W-1:0] count,
    output logic empty,
    output logic full
);
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;

    assign wr_ptr = wr_ptr_reg;
    assign rd_ptr = rd_ptr_reg;
    assign count = wr_ptr_reg - rd_ptr_reg;
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (count >= depth);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (clear)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
        end
    end
endmodule : buffer_tracker
`default_nettype wire

/* File: serial_status_flags.sv */
// status, flag and buffer-occupancy logic of a serial port
// assumes shifter and word storage live outside, on the same clock
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module serial_status_flags
    import serial_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // shifter side
    input wire logic shift_active,
    input wire logic shift_reg_empty_in,
    input wire logic rx_word_done,
    input wire logic tx_word_needed,
    input wire logic frame_error_detect,
    // word storage side
    input wire logic [DATA_W-1:0] rx_word,
    output logic [IDX_W-1:0] rx_read_index,
    output logic rx_store,
    output logic [IDX_W-1:0] rx_store_index,
    output logic tx_load,
    output logic [DATA_W-1:0] tx_load_data,
    output logic [IDX_W-1:0] tx_load_index,
    output logic tx_take,
    output logic [IDX_W-1:0] tx_take_index,
    // mode outputs
    output control_t control,
    // interrupt
    output logic irq
);
    // register file
    control_t control_reg;
    control_t control_next;
    logic [FLAG_W-1:0] int_status_reg;
    logic [FLAG_W-1:0] int_status_next;
    logic [FLAG_W-1:0] int_mask_reg;
    logic [FLAG_W-1:0] int_mask_next;
    logic irq_reg;
    logic irq_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    // mirrors and storage strobes
    logic activity_reg;
    logic activity_next;
    logic shift_empty_reg;
    logic rx_store_reg;
    logic [IDX_W-1:0] rx_store_index_reg;
    logic tx_load_reg;
    logic [DATA_W-1:0] tx_load_data_reg;
    logic [IDX_W-1:0] tx_load_index_reg;
    logic tx_take_reg;
    logic [IDX_W-1:0] tx_take_index_reg;

    // address decode
    wire sel_status = (reg_addr == OFS_STATUS);
    wire sel_control = (reg_addr == OFS_CONTROL);
    wire sel_data = (reg_addr == OFS_DATA);
    wire sel_int_status = (reg_addr == OFS_INT_STATUS);
    wire sel_int_mask = (reg_addr == OFS_INT_MASK);
    wire wr_status = reg_wr & sel_status;
    wire wr_control = reg_wr & sel_control;
    wire wr_data = reg_wr & sel_data;
    wire wr_int_status = reg_wr & sel_int_status;
    wire wr_int_mask = reg_wr & sel_int_mask;
    wire rd_data = reg_rd & sel_data;

    wire on = control_reg.on;
    wire enh = control_reg.enhanced_buffer_enable;
    wire framed = control_reg.framed_mode_enable;
    wire [PTR_W-1:0] depth = enh ? DEPTH_ENHANCED : DEPTH_STANDARD;
    // disabled module holds the three sticky flags and both buffers cleared until re-enabled; interrupt status bits keep their value
    wire off_clear = ~on;

    // buffer state
    wire [PTR_W-1:0] rx_wr_ptr;
    wire [PTR_W-1:0] rx_rd_ptr;
    wire [PTR_W-1:0] rx_count;
    wire rx_empty;
    wire rx_full;
    wire [PTR_W-1:0] tx_wr_ptr;
    wire [PTR_W-1:0] tx_rd_ptr;
    wire [PTR_W-1:0] tx_count;
    wire tx_empty;
    wire tx_full;

    // events of this cycle
    wire rx_arrive = on & rx_word_done;
    wire rx_push = rx_arrive & ~rx_full;
    wire rx_discard = rx_arrive & rx_full;
    // a data read with nothing stored leaves the pointer where it is
    wire rx_pop = on & rd_data & ~rx_empty;
    wire tx_push = on & wr_data & ~tx_full;
    wire tx_demand = on & tx_word_needed;
    wire tx_pop = tx_demand & ~tx_empty;
    wire tx_dry = tx_demand & tx_empty & framed;
    wire frame_err_ev = on & framed & frame_error_detect;

    // events that set interrupt status bits
    events_t ev;
    assign ev = '{
        frame_error: frame_err_ev,
        tx_underrun: tx_dry,
        rx_overflow: rx_discard,
        rx_word: rx_push
    };

    buffer_tracker rx_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(off_clear),
        .push(rx_push),
        .pop(rx_pop),
        .depth(depth),
        .wr_ptr(rx_wr_ptr),
        .rd_ptr(rx_rd_ptr),
        .count(rx_count),
        .empty(rx_empty),
        .full(rx_full)
    );

    buffer_tracker tx_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(off_clear),
        .push(tx_push),
        .pop(tx_pop),
        .depth(depth),
        .wr_ptr(tx_wr_ptr),
        .rd_ptr(tx_rd_ptr),
        .count(tx_count),
        .empty(tx_empty),
        .full(tx_full)
    );

    // sticky flags: cleared while disabled or by writing zero to the bit
    wire frame_err_flag;
    wire tx_underrun_flag;
    wire rx_overflow_flag;
    wire clr_frame_err = off_clear | (wr_status & ~reg_wdata[POS_FRAME_ERR]);
    wire clr_underrun = off_clear | (wr_status & ~reg_wdata[POS_TX_UNDERRUN]);
    wire clr_overflow = off_clear | (wr_status & ~reg_wdata[POS_RX_OVERFLOW]);

    sticky_flag frame_err_bit (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(frame_err_ev),
        .clear(clr_frame_err),
        .flag(frame_err_flag)
    );

    sticky_flag underrun_bit (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(tx_dry),
        .clear(clr_underrun),
        .flag(tx_underrun_flag)
    );

    sticky_flag overflow_bit (
        .clk_sys(clk_sys),
        .rst(rst),
        .set(rx_discard),
        .clear(clr_overflow),
        .flag(rx_overflow_flag)
    );

    // status word; every bit not listed reads zero
    logic [DATA_W-1:0] status_word;
    always_comb
    begin
        status_word = '0;
        status_word[POS_RX_COUNT +: PTR_W] = rx_count;
        status_word[POS_TX_COUNT +: PTR_W] = tx_count;
        status_word[POS_FRAME_ERR] = frame_err_flag;
        status_word[POS_ACTIVITY] = activity_reg;
        status_word[POS_TX_UNDERRUN] = tx_underrun_flag;
        status_word[POS_SHIFT_EMPTY] = shift_empty_reg;
        status_word[POS_RX_OVERFLOW] = rx_overflow_flag;
        status_word[POS_RX_EMPTY] = rx_empty;
        status_word[POS_TX_EMPTY] = tx_empty;
        status_word[POS_TX_FULL] = tx_full;
        status_word[POS_RX_FULL] = rx_full;
    end

    // register words as read back, unused bits zero
    wire [DATA_W-1:0] control_word = {29'h0000_0000, control_reg};
    wire [DATA_W-1:0] int_status_word = {28'h000_0000, int_status_reg};
    wire [DATA_W-1:0] int_mask_word = {28'h000_0000, int_mask_reg};

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rdata_next = '0;
        if (reg_rd)
        begin
            if (sel_status)
                rdata_next = status_word;
            else if (sel_control)
                rdata_next = control_word;
            else if (sel_data)
                rdata_next = rx_word;
            else if (sel_int_status)
                rdata_next = int_status_word;
            else if (sel_int_mask)
                rdata_next = int_mask_word;
        end
    end

    // event bits set, write one clears, set wins
    assign int_status_next = ev | (int_status_reg & ~(wr_int_status ? reg_wdata[FLAG_W-1:0]
        : RST_FLAGS));

    // mode and mask take a write at once, so irq follows the new mask
    assign control_next = wr_control ? control_t'(reg_wdata[POS_FRAMED:POS_ON]) : control_reg;
    assign int_mask_next = wr_int_mask ? reg_wdata[FLAG_W-1:0] : int_mask_reg;
    assign irq_next = |(int_status_next & int_mask_next);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            control_reg <= RST_CONTROL;
            int_mask_reg <= RST_FLAGS;
            int_status_reg <= RST_FLAGS;
            irq_reg <= 1'b0;
            rdata_reg <= RST_WORD;
        end
        else
        begin
            control_reg <= control_next;
            int_mask_reg <= int_mask_next;
            int_status_reg <= int_status_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    // busy while shifting or while words wait to go out
    assign activity_next = on & (shift_active | ~tx_empty | tx_push);

    // shifter mirrors
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            activity_reg <= 1'b0;
            shift_empty_reg <= RST_SHIFT_EMPTY;
        end
        else
        begin
            activity_reg <= activity_next;
            shift_empty_reg <= shift_reg_empty_in;
        end
    end

    // word storage strobes with the slot they refer to
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_store_reg <= 1'b0;
            rx_store_index_reg <= '0;
            tx_load_reg <= 1'b0;
            tx_load_data_reg <= RST_WORD;
            tx_load_index_reg <= '0;
            tx_take_reg <= 1'b0;
            tx_take_index_reg <= '0;
        end
        else
        begin
            rx_store_reg <= rx_push;
            tx_load_reg <= tx_push;
            tx_take_reg <= tx_pop;
            if (rx_push)
                rx_store_index_reg <= rx_wr_ptr[IDX_W-1:0];
            if (tx_push)
            begin
                tx_load_data_reg <= reg_wdata;
                tx_load_index_reg <= tx_wr_ptr[IDX_W-1:0];
            end
            if (tx_pop)
                tx_take_index_reg <= tx_rd_ptr[IDX_W-1:0];
        end
    end

    assign reg_rdata = rdata_reg;
    // index from the pointer flop, so rx_word settles before the read
    assign rx_read_index = rx_rd_ptr[IDX_W-1:0];
    assign rx_store = rx_store_reg;
    assign rx_store_index = rx_store_index_reg;
    assign tx_load = tx_load_reg;
    assign tx_load_data = tx_load_data_reg;
    assign tx_load_index = tx_load_index_reg;
    assign tx_take = tx_take_reg;
    assign tx_take_index = tx_take_index_reg;
    assign control = control_reg;
    assign irq = irq_reg;
endmodule : serial_status_flags
`default_nettype wire

/* File: serial_status_monitor.sv */
// assertion checker for the serial status block
// assumes it is bound to the block's top module
`timescale 1ns/1ps
`default_nettype none
module serial_status_monitor
    import serial_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // shifter side, receive store strobe and mode
    input wire logic shift_active,
    input wire logic shift_reg_empty_in,
    input wire logic rx_word_done,
    input wire logic tx_word_needed,
    input wire logic rx_store,
    input wire control_t control
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire rd_st = reg_rd && reg_addr == OFS_STATUS;
    wire wr_st = reg_wr && reg_addr == OFS_STATUS;
    sequence s_clr_ovf;
        !$past(rx_word_done) && wr_st && !reg_wdata[POS_RX_OVERFLOW] && !rx_word_done
        ##1 (!rx_word_done)[*2] ##0 rd_st;
    endsequence
    sequence s_clr_urun;
        !$past(tx_word_needed) && wr_st && !reg_wdata[POS_TX_UNDERRUN] && !tx_word_needed
        ##1 (!tx_word_needed)[*2] ##0 rd_st;
    endsequence
    sequence s_two_rd;
        rd_st ##1 (rd_st && reg_rdata[POS_RX_OVERFLOW]);
    endsequence
    sequence s_busy;
        (shift_active && control.on)[*3] ##0 rd_st;
    endsequence
    a_unused_bits_zero:
        assert property (rd_st |=> (reg_rdata & 32'he0e0_e614) == 32'h0)
        else $error("unused status bit set");
    a_store_needs_word:
        assert property (rx_store |-> $past(rx_word_done))
        else $error("store without finished word");
    a_busy_shown:
        assert property (s_busy |=> reg_rdata[POS_ACTIVITY])
        else $error("activity flag low while busy");
    a_shift_mirror:
        assert property (($stable(shift_reg_empty_in))[*3] ##0 rd_st
            |=> reg_rdata[POS_SHIFT_EMPTY] == $past(shift_reg_empty_in))
        else $error("shift empty flag wrong");
    a_ovf_clear:
        assert property (s_clr_ovf |=> !reg_rdata[POS_RX_OVERFLOW])
        else $error("overflow flag not cleared");
    a_urun_clear:
        assert property (s_clr_urun |=> !reg_rdata[POS_TX_UNDERRUN])
        else $error("underrun flag not cleared");
    a_ovf_sticky:
        assert property (s_two_rd |=> reg_rdata[POS_RX_OVERFLOW])
        else $error("overflow flag lost");
    a_rx_empty_count:
        assert property (rd_st |=> reg_rdata[POS_RX_EMPTY] == (reg_rdata[28:24] == 5'h0))
        else $error("rx empty flag disagrees with count");
endmodule : serial_status_monitor
bind serial_status_flags serial_status_monitor i_monitor (
    .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .shift_active, .shift_reg_empty_in, .rx_word_done, .tx_word_needed,
    .rx_store, .control
);
`default_nettype wire

/* File: serial_peer_model.sv */
// behavioural shifter and receive storage facing the status block
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model
    import serial_status_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // receive storage
    input wire logic rx_store,
    input wire logic [IDX_W-1:0] rx_store_index,
    input wire logic [IDX_W-1:0] rx_read_index,
    output logic [DATA_W-1:0] rx_word,
    // shifter
    output logic shift_active,
    output logic shift_reg_empty_in,
    output logic rx_word_done,
    output logic tx_word_needed,
    output logic frame_error_detect
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] word_reg;
    assign rx_word = mem[rx_read_index];
    initial
    begin
        {shift_active, rx_word_done, tx_word_needed, frame_error_detect} = 4'h0;
        shift_reg_empty_in = 1'b1;
    end
    // stored words are numbered so read order shows
    always @(posedge clk_sys or posedge rst)
        if (rst)
            word_reg <= 32'h5a00_0000;
        else if (rx_store)
        begin
            mem[rx_store_index] <= word_reg;
            word_reg <= word_reg + 32'h1;
        end
    task automatic pulse(input logic [2:0] k);
        {frame_error_detect, tx_word_needed, rx_word_done} <= k;
        @(posedge clk_sys);
        {frame_error_detect, tx_word_needed, rx_word_done} <= 3'h0;
        @(posedge clk_sys);
    endtask : pulse
    task automatic level(input logic a, input logic e);
        shift_active <= a;
        shift_reg_empty_in <= e;
        repeat (3) @(posedge clk_sys);
    endtask : level
endmodule : serial_peer_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench of the serial status block
// assumes the peer model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench
    import serial_status_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata, rx_word, tx_load_data;
    logic shift_active, shift_reg_empty_in, rx_word_done, tx_word_needed;
    logic frame_error_detect, rx_store, tx_load, tx_take, irq, rd_d;
    logic [IDX_W-1:0] rx_read_index, rx_store_index, tx_load_index, tx_take_index;
    control_t control;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [DATA_W-1:0] exp_q[$], msk_q[$];
    logic [DATA_W-1:0] load_q[$];
    logic [DATA_W-1:0] wdata_rand;
    int n_load = 0;
    int n_take = 0;
    serial_status_flags i_dut (
        .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .shift_active, .shift_reg_empty_in, .rx_word_done, .tx_word_needed,
        .frame_error_detect, .rx_word, .rx_read_index, .rx_store, .rx_store_index,
        .tx_load, .tx_load_data, .tx_load_index, .tx_take, .tx_take_index,
        .control, .irq
    );
    serial_peer_model i_peer (
        .clk_sys, .rst, .rx_store, .rx_store_index, .rx_read_index, .rx_word,
        .shift_active, .shift_reg_empty_in, .rx_word_done, .tx_word_needed,
        .frame_error_detect
    );
    always #12.5 clk_sys = ~clk_sys;
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [DATA_W-1:0] got, exp, msk);
        n_checks++;
        if ((got & msk) !== (exp & msk))
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // irq is looked at mid-cycle, where it is settled
    task automatic chk_irq(input logic e);
        @(negedge clk_sys);
        chk({31'h0, irq}, {31'h0, e}, 32'h1);
        @(posedge clk_sys);
    endtask : chk_irq
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, m,
                      input int n = 1);
        repeat (n)
        begin
            reg_rd <= 1'b1;
            reg_addr <= a;
            exp_q.push_back(e);
            msk_q.push_back(m);
            @(posedge clk_sys);
        end
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask : rd
    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys)
        rd_d <= reg_rd;
    always @(negedge clk_sys)
    begin
        if (rd_d === 1'b1)
            chk(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
        if (tx_load === 1'b1)
        begin
            chk(tx_load_data, load_q.pop_front(), '1);
            chk({28'h0, tx_load_index}, n_load % 16, 32'hf);
            n_load++;
        end
        if (tx_take === 1'b1)
        begin
            chk({28'h0, tx_take_index}, n_take % 16, 32'hf);
            n_take++;
        end
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            test_done();
        end
    end
    initial
    begin
        void'($urandom(14));
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(OFS_STATUS, 32'h0000_00a8, '1);
        rd(8'h20, 32'h0, '1);
        wr(OFS_CONTROL, 32'h7);
        rd(OFS_CONTROL, 32'h7, 32'h7);
        chk({29'h0, control}, 32'h7, 32'h7);
        for (int i = 0; i < 17; i++)
        begin
            wdata_rand = $urandom;
            if (i < 16)
                load_q.push_back(wdata_rand);
            wr(OFS_DATA, wdata_rand);
        end
        rd(OFS_STATUS, 32'h0010_08a2, '1);
        repeat (17) i_peer.pulse(3'b010);
        rd(OFS_STATUS, 32'h0000_01a8, '1);
        wr(OFS_STATUS, '1);
        rd(OFS_STATUS, 32'h100, 32'h100);
        wr(OFS_STATUS, 32'h0);
        rd(OFS_STATUS, 32'h0, 32'h100);
        repeat (17) i_peer.pulse(3'b001);
        rd(OFS_STATUS, 32'h1000_00c9, '1, 2);
        rd(OFS_DATA, 32'h5a00_0000, '1);
        rd(OFS_DATA, 32'h5a00_0001, '1);
        rd(OFS_STATUS, 32'h0e00_00c8, '1);
        wr(OFS_STATUS, 32'hffff_ffbf);
        rd(OFS_STATUS, 32'h0e00_0088, '1);
        repeat (3) i_peer.pulse(3'b001);
        i_peer.pulse(3'b010);
        rd(OFS_STATUS, 32'h1000_01c9, '1);
        wr(OFS_CONTROL, 32'h0);
        wr(OFS_CONTROL, 32'h3);
        rd(OFS_STATUS, 32'h0000_00a8, '1);
        i_peer.pulse(3'b100);
        rd(OFS_STATUS, 32'h0, 32'h1000);
        wr(OFS_CONTROL, 32'h7);
        i_peer.pulse(3'b100);
        rd(OFS_STATUS, 32'h1000, 32'h1000);
        wr(OFS_STATUS, 32'hffff_efff);
        rd(OFS_STATUS, 32'h0, 32'h1000);
        i_peer.level(1'b1, 1'b0);
        rd(OFS_STATUS, 32'h820, 32'h8a0);
        i_peer.level(1'b0, 1'b1);
        rd(OFS_STATUS, 32'ha0, 32'h8a0);
        wr(OFS_INT_MASK, 32'h0);
        chk_irq(1'b0);
        wr(OFS_INT_MASK, 32'hf);
        chk_irq(1'b1);
        rd(OFS_INT_STATUS, 32'h1, 32'h1);
        wr(OFS_INT_STATUS, 32'hf);
        chk_irq(1'b0);
        chk(n_load, 32'd16, '1);
        chk(n_take, 32'd16, '1);
        test_done();
    end
endmodule : testbench
`default_nettype wire
